/* File: core/sbsel_pkg.sv */
// Purpose: Shared constants and carriers for the sideband status/event block
// Assumes: Single 10 MHz clock domain
// Notes:   Timing counts derive from the clock rate below
package sbsel_pkg;
  // Clock and timing
  localparam int CLK_HZ         = 10_000_000;
  localparam int EJECT_HOLD_MS  = 10;
  localparam int EJECT_HOLD_CYC = EJECT_HOLD_MS * (CLK_HZ / 1000);
  localparam int STRAP_SETTLE   = 3;

  // Test-select codes
  localparam logic [3:0] TST_NORMAL   = 4'h0;
  localparam logic [3:0] TST_ISOLATE  = 4'h2;
  localparam logic [3:0] TST_IN_CHAIN = 4'h3;
  localparam logic [3:0] TST_BI_CHAIN = 4'h4;

  // Configuration bit positions
  localparam int CFG0E_USER_LSB = 3;
  localparam int CFG0B_MPV_POL  = 4;
  localparam int CFG0B_MPV_EN   = 2;

  // Pin group widths
  localparam int N_DED  = 11;
  localparam int N_BIDI = 20;
  localparam int N_OUTO = 14;
  localparam int N_GPIO = 3;

  // Reset values
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [4:0]  MEDIA_RST  = 5'h01;

  // Interrupt pipe status word
  typedef struct packed {
    logic [4:0]        zero;
    logic              drive_ready;
    logic              high_speed;
    logic              bus_powered;
    logic [4:0]        user_bits;
    logic [N_GPIO-1:0] gpio;
  } sbsel_status_t;

  // Media-present and ATA-enable consequences
  typedef struct packed {
    logic dplus_pullup_en;
    logic ata_halt;
    logic low_power;
    logic ata_drive_low;
    logic ata_pins_oe_n;
  } sbsel_media_t;
endpackage

/* File: core/sbsel_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Destination is mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module sbsel_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_meta_ff;
  logic [W-1:0] nxt_q_ff;

  always_comb begin
    nxt_meta_ff = clk_en ? d : meta_ff;
    nxt_q_ff    = clk_en ? meta_ff : q_ff;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= nxt_meta_ff;
      q_ff    <= nxt_q_ff;
    end
  end

  assign q = q_ff;
endmodule
`default_nettype wire

/* File: core/sbsel_chain.sv */
// Purpose: Cumulative XNOR connectivity chain
// Assumes: Inputs already synchronised
// Notes:   Output j shows chain stage j modulo the input count
`timescale 1ns/1ns
`default_nettype none
module sbsel_chain #(
  parameter int N_IN  = 11,
  parameter int N_OUT = 20
) (
  // Chain inputs
  input  wire logic [N_IN-1:0]  din,
  // Chain outputs
  output logic      [N_OUT-1:0] dout
);
  logic [N_IN-1:0] stage;

  assign stage[0] = din[0];
  for (genvar i = 1; i < N_IN; i++) begin : g_stage
    assign stage[i] = ~(stage[i-1] ^ din[i]);
  end
  for (genvar j = 0; j < N_OUT; j++) begin : g_out
    assign dout[j] = stage[j % N_IN];
  end
endmodule
`default_nettype wire

/* File: core/sbsel_top.sv */
// Purpose: Sideband test-mode, eject, service-request and media-present logic
// Assumes: Config bytes, speed flag, suspend, wake enable and token come from mclk logic; all else are pins
// Notes:   Test code is captured once after reset release
//
// Behaviour
// - Straps low select normal; codes other than 2, 3, 4 reserved
// - Isolation code floats all outputs but oscillator
// - Input chain code drives results on bidi pins
// - Bidi chain code drives results on outputs
// - Eject held 10 ms raises eject request
// - Suspended, wake enabled: eject edge wakes host
// - Nothing pending: interrupt requests get NAK
// - Pending request returns one 16-bit status word
// - Upper byte: zeros, ready, speed, bus power
// - Lower byte: user bits then GPIO states
// - Media polarity and enable from config 0x0B
// - Media absent releases D+ pull-up
// - Media absent halts ATA, low power, drive low if ATA enabled
// - Media back reconnects and resumes ATA
// - ATA enable low floats ATA pins, halts
`timescale 1ns/1ns
`default_nettype none
module sbsel_top
  import sbsel_pkg::*;
#(
  parameter int HOLD_CYC = sbsel_pkg::EJECT_HOLD_CYC
) (
  // Clock and reset
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire logic                          clk_en,
  // Test straps and chain pins
  input  wire logic [3:0]                    test_sel,
  input  wire logic [sbsel_pkg::N_DED-1:0]   chain_ded_in,
  input  wire logic [sbsel_pkg::N_BIDI-1:0]  bidi_in,
  output logic      [sbsel_pkg::N_BIDI-1:0]  bidi_out,
  output logic                               bidi_oe_n,
  output logic      [sbsel_pkg::N_OUTO-1:0]  chain_out_only,
  output logic                               out_only_chain_sel,
  output logic                               pads_hiz,
  // Eject and wakeup
  input  wire logic                          eject_button_n,
  input  wire logic                          usb_suspended,
  input  wire logic                          remote_wake_enabled,
  output logic                               eject_request,
  output logic                               remote_wakeup,
  // Service request and interrupt pipe
  input  wire logic                          system_service_request,
  input  wire logic                          drive_ready_in,
  input  wire logic                          high_speed_active,
  input  wire logic                          bus_powered_select,
  input  wire logic [sbsel_pkg::N_GPIO-1:0]  gpio_in,
  input  wire logic [7:0]                    cfg_byte_0e,
  input  wire logic                          intr_in_token,
  output logic                               intr_data_valid,
  output logic                               intr_nak,
  output sbsel_pkg::sbsel_status_t           intr_data,
  output logic                               intr_pending,
  // Media present and ATA sharing
  input  wire logic [7:0]                    cfg_byte_0b,
  input  wire logic                          media_present_valid,
  input  wire logic                          ata_bus_enable,
  output sbsel_pkg::sbsel_media_t            media_ctl
);
  import sbsel_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  // Synchronised pins
  logic [3:0]        test_s;
  logic [N_DED-1:0]  ded_s;
  logic [N_BIDI-1:0] bidi_s;
  logic [N_GPIO-1:0] gpio_s;
  logic              eject_n_s;
  logic              sysreq_s;
  logic              ready_s;
  logic              buspwr_s;
  logic              media_s;
  logic              ata_bus_enable_s;
  logic [N_BIDI-1:0] in_chain;
  logic [N_OUTO-1:0] bi_chain;

  sbsel_sync #(.W(4)) u_sync_test (
    .mclk(mclk), .resetn(resetn), .clk_en(clk_en), .d(test_sel), .q(test_s)
  );
  sbsel_sync #(.W(N_DED + N_BIDI + N_GPIO + 6)) u_sync_pins (
    .mclk  (mclk),
    .resetn(resetn),
    .clk_en(clk_en),
    .d     ({chain_ded_in, bidi_in, gpio_in, eject_button_n,
             system_service_request, drive_ready_in, bus_powered_select,
             media_present_valid, ata_bus_enable}),
    .q     ({ded_s, bidi_s, gpio_s, eject_n_s, sysreq_s, ready_s, buspwr_s,
             media_s, ata_bus_enable_s})
  );
  sbsel_chain #(.N_IN(N_DED), .N_OUT(N_BIDI)) u_in_chain (
    .din(ded_s), .dout(in_chain)
  );
  sbsel_chain #(.N_IN(N_BIDI), .N_OUT(N_OUTO)) u_bi_chain (
    .din(bidi_s), .dout(bi_chain)
  );

  // Test mode capture: straps must settle before reset release
  logic [1:0]        settle_ff, nxt_settle_ff;
  logic [3:0]        mode_ff, nxt_mode_ff;
  logic [N_BIDI-1:0] bidi_out_ff, nxt_bidi_out_ff;
  logic              bidi_oe_n_ff, nxt_bidi_oe_n_ff;
  logic [N_OUTO-1:0] outo_ff, nxt_outo_ff;
  logic              outo_sel_ff, nxt_outo_sel_ff;
  logic              hiz_ff, nxt_hiz_ff;

  always_comb begin
    nxt_settle_ff    = settle_ff;
    nxt_mode_ff      = mode_ff;
    if (settle_ff != 2'(STRAP_SETTLE)) begin
      nxt_settle_ff = settle_ff + 2'h1;
      nxt_mode_ff   = test_s;
    end
    nxt_hiz_ff       = (mode_ff == TST_ISOLATE);
    nxt_bidi_oe_n_ff = !(mode_ff == TST_IN_CHAIN);
    nxt_bidi_out_ff  = (mode_ff == TST_IN_CHAIN) ? in_chain : '0;
    nxt_outo_sel_ff  = (mode_ff == TST_BI_CHAIN);
    nxt_outo_ff      = (mode_ff == TST_BI_CHAIN) ? bi_chain : '0;
    if (!clk_en) begin
      nxt_settle_ff    = settle_ff;
      nxt_mode_ff      = mode_ff;
      nxt_hiz_ff       = hiz_ff;
      nxt_bidi_oe_n_ff = bidi_oe_n_ff;
      nxt_bidi_out_ff  = bidi_out_ff;
      nxt_outo_sel_ff  = outo_sel_ff;
      nxt_outo_ff      = outo_ff;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_ff    <= 2'h0;
      mode_ff      <= TST_NORMAL;
      hiz_ff       <= 1'b0;
      bidi_oe_n_ff <= 1'b1;
      bidi_out_ff  <= '0;
      outo_sel_ff  <= 1'b0;
      outo_ff      <= '0;
    end else begin
      settle_ff    <= nxt_settle_ff;
      mode_ff      <= nxt_mode_ff;
      hiz_ff       <= nxt_hiz_ff;
      bidi_oe_n_ff <= nxt_bidi_oe_n_ff;
      bidi_out_ff  <= nxt_bidi_out_ff;
      outo_sel_ff  <= nxt_outo_sel_ff;
      outo_ff      <= nxt_outo_ff;
    end
  end

  // Normal function only under the all-zero code
  logic normal_mode;
  assign normal_mode = (mode_ff == TST_NORMAL) && (settle_ff == 2'(STRAP_SETTLE));

  // Eject hold timer and remote wakeup
  logic [CW-1:0] hold_ff, nxt_hold_ff;
  logic          eject_ff, nxt_eject_ff;
  logic          wake_ff, nxt_wake_ff;
  logic          eject_prev_ff, nxt_eject_prev_ff;

  always_comb begin
    nxt_hold_ff       = hold_ff;
    nxt_eject_ff      = 1'b0;
    nxt_wake_ff       = 1'b0;
    nxt_eject_prev_ff = eject_n_s;
    if (!normal_mode || eject_n_s || usb_suspended) begin
      nxt_hold_ff = '0;
    end else if (hold_ff != CW'(HOLD_CYC)) begin
      nxt_hold_ff = hold_ff + CW'(1);
      // One request per press, fired on the last count
      nxt_eject_ff = (hold_ff == CW'(HOLD_CYC - 1));
    end
    if (normal_mode && usb_suspended && remote_wake_enabled &&
        (eject_n_s != eject_prev_ff)) begin
      nxt_wake_ff = 1'b1;
    end
    if (!clk_en) begin
      nxt_hold_ff       = hold_ff;
      nxt_eject_ff      = eject_ff;
      nxt_wake_ff       = wake_ff;
      nxt_eject_prev_ff = eject_prev_ff;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_ff       <= '0;
      eject_ff      <= 1'b0;
      wake_ff       <= 1'b0;
      eject_prev_ff <= 1'b1;
    end else begin
      hold_ff       <= nxt_hold_ff;
      eject_ff      <= nxt_eject_ff;
      wake_ff       <= nxt_wake_ff;
      eject_prev_ff <= nxt_eject_prev_ff;
    end
  end

  // Service request latch and interrupt pipe answer
  logic          pend_ff, nxt_pend_ff;
  sbsel_status_t snap_ff, nxt_snap_ff;
  sbsel_status_t data_ff, nxt_data_ff;
  logic          dval_ff, nxt_dval_ff;
  logic          nak_ff, nxt_nak_ff;
  logic          sysreq_prev_ff, nxt_sysreq_prev_ff;
  sbsel_status_t live;

  always_comb begin
    live.zero        = 5'h00;
    live.drive_ready = ready_s;
    live.high_speed  = high_speed_active;
    live.bus_powered = buspwr_s;
    live.user_bits   = cfg_byte_0e[CFG0E_USER_LSB +: 5];
    live.gpio        = gpio_s;
  end

  always_comb begin
    nxt_pend_ff        = pend_ff;
    nxt_snap_ff        = snap_ff;
    nxt_data_ff        = data_ff;
    nxt_dval_ff        = 1'b0;
    nxt_nak_ff         = 1'b0;
    nxt_sysreq_prev_ff = sysreq_s;
    if (normal_mode && intr_in_token) begin
      if (pend_ff) begin
        nxt_dval_ff = 1'b1;
        nxt_data_ff = snap_ff;
        nxt_pend_ff = 1'b0;
      end else begin
        nxt_nak_ff = 1'b1;
      end
    end
    // New request wins over a same-cycle delivery
    if (normal_mode && sysreq_s && !sysreq_prev_ff) begin
      nxt_pend_ff = 1'b1;
      nxt_snap_ff = live;
    end
    if (!clk_en) begin
      nxt_pend_ff        = pend_ff;
      nxt_snap_ff        = snap_ff;
      nxt_data_ff        = data_ff;
      nxt_dval_ff        = dval_ff;
      nxt_nak_ff         = nak_ff;
      nxt_sysreq_prev_ff = sysreq_prev_ff;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_ff        <= 1'b0;
      snap_ff        <= STATUS_RST;
      data_ff        <= STATUS_RST;
      dval_ff        <= 1'b0;
      nak_ff         <= 1'b0;
      sysreq_prev_ff <= 1'b0;
    end else begin
      pend_ff        <= nxt_pend_ff;
      snap_ff        <= nxt_snap_ff;
      data_ff        <= nxt_data_ff;
      dval_ff        <= nxt_dval_ff;
      nak_ff         <= nxt_nak_ff;
      sysreq_prev_ff <= nxt_sysreq_prev_ff;
    end
  end

  // Media present and ATA bus sharing
  sbsel_media_t media_ff, nxt_media_ff;
  logic         present;

  always_comb begin
    present = cfg_byte_0b[CFG0B_MPV_EN] ?
              (media_s == cfg_byte_0b[CFG0B_MPV_POL]) : 1'b1;
    nxt_media_ff.dplus_pullup_en = present && !hiz_ff;
    nxt_media_ff.ata_halt        = !present || !ata_bus_enable_s;
    nxt_media_ff.low_power       = !present;
    nxt_media_ff.ata_drive_low   = !present && ata_bus_enable_s;
    // Floating wins in isolation; media presence never changes the pin enable
    nxt_media_ff.ata_pins_oe_n   = !ata_bus_enable_s || hiz_ff;
    if (!clk_en) begin
      nxt_media_ff = media_ff;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      media_ff <= MEDIA_RST;
    end else begin
      media_ff <= nxt_media_ff;
    end
  end

  // Outputs
  assign bidi_out           = bidi_out_ff;
  assign bidi_oe_n          = bidi_oe_n_ff;
  assign chain_out_only     = outo_ff;
  assign out_only_chain_sel = outo_sel_ff;
  assign pads_hiz           = hiz_ff;
  assign eject_request      = eject_ff;
  assign remote_wakeup      = wake_ff;
  assign intr_data_valid    = dval_ff;
  assign intr_nak           = nak_ff;
  assign intr_data          = data_ff;
  assign intr_pending       = pend_ff;
  assign media_ctl          = media_ff;
endmodule
`default_nettype wire

/* File: verif/sbsel_top_properties.sv */
// Purpose: Port-level checks for the sideband block
// Assumes: Straps change only while reset is held
// Notes:   Pin paths allow a few cycles of sync delay
`timescale 1ns/1ns
`default_nettype none
module sbsel_top_properties
  import sbsel_pkg::*;
#(
  parameter int HOLD_CYC = 20
) (
  // Clock and reset
  input wire logic                     mclk,
  input wire logic                     resetn,
  // Test straps
  input wire logic [3:0]               test_sel,
  input wire logic                     bidi_oe_n,
  input wire logic                     out_only_chain_sel,
  input wire logic                     pads_hiz,
  // Eject and wakeup
  input wire logic                     eject_button_n,
  input wire logic                     usb_suspended,
  input wire logic                     remote_wake_enabled,
  input wire logic                     eject_request,
  input wire logic                     remote_wakeup,
  // Interrupt pipe
  input wire logic                     system_service_request,
  input wire logic                     intr_in_token,
  input wire logic                     intr_data_valid,
  input wire logic                     intr_nak,
  input wire sbsel_pkg::sbsel_status_t intr_data,
  input wire logic                     intr_pending,
  // Media
  input wire logic [7:0]               cfg_byte_0b,
  input wire logic                     media_present_valid,
  input wire logic                     ata_bus_enable,
  input wire sbsel_pkg::sbsel_media_t  media_ctl
);
  import sbsel_pkg::*;
  logic [3:0]  up_ff;
  logic [3:0]  nxt_up;
  logic [31:0] low_ff;
  logic [31:0] nxt_low;
  logic        tm;
  logic        ok;
  logic        present;
  always_comb begin
    nxt_up  = (up_ff == 4'hF) ? up_ff : up_ff + 4'h1;
    nxt_low = eject_button_n ? 32'h0 : low_ff + 32'h1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      up_ff  <= 4'h0;
      low_ff <= 32'h0;
    end else begin
      up_ff  <= nxt_up;
      low_ff <= nxt_low;
    end
  end
  // Mode outputs only trusted once the strap capture has settled
  assign tm      = up_ff > 4'h7;
  assign ok      = tm && test_sel == 4'h0;
  assign present = !cfg_byte_0b[2] || media_present_valid == cfg_byte_0b[4];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_isolate_float: assert property (
    tm && test_sel == 4'h2 |-> pads_hiz && bidi_oe_n && !out_only_chain_sel)
    else $error("isolation outputs wrong");
  a_chain_modes: assert property (
    tm |-> bidi_oe_n == (test_sel != 4'h3) && out_only_chain_sel == (test_sel == 4'h4))
    else $error("chain mode outputs wrong");
  a_eject_hold: assert property (
    eject_request |-> $past(low_ff, 2) >= HOLD_CYC - 2)
    else $error("eject request too early");
  a_eject_single: assert property (
    eject_request |=> !eject_request [*8])
    else $error("eject request repeated");
  a_wake_on_change: assert property (
    ok && usb_suspended && remote_wake_enabled && $changed(eject_button_n)
    |-> ##[1:5] remote_wakeup)
    else $error("wakeup missing");
  a_nak_when_idle: assert property (
    ok && intr_in_token && !intr_pending |=> intr_nak && !intr_data_valid)
    else $error("idle poll not refused");
  a_word_on_pending: assert property (
    ok && intr_in_token && intr_pending |=> intr_data_valid && !intr_nak)
    else $error("pending word not sent");
  a_status_zero: assert property (
    intr_data_valid |-> intr_data.zero == 5'h00)
    else $error("status top bits not zero");
  a_request_latch: assert property (
    ok && $rose(system_service_request) ##0 !intr_in_token [*3] |=> ##[0:1] intr_pending)
    else $error("request not latched");
  a_pending_clears: assert property (
    ok && !system_service_request [*3] ##0 intr_in_token && intr_pending |=> !intr_pending)
    else $error("pending not cleared");
  // Media pin lags the config byte by the sync, so both must sit still first
  a_media_absent: assert property (
    (ok && !present && $stable(cfg_byte_0b) && $stable(media_present_valid)) [*4]
    |=> !media_ctl.dplus_pullup_en && media_ctl.low_power)
    else $error("absent media not handled");
  a_media_back: assert property (
    (ok && present && $stable(cfg_byte_0b) && $stable(media_present_valid)) [*4]
    |=> media_ctl.dplus_pullup_en && !media_ctl.low_power)
    else $error("media return not handled");
  a_ata_drive_low: assert property (
    (ok && !present && ata_bus_enable && $stable(cfg_byte_0b) &&
     $stable(media_present_valid)) [*4]
    |=> media_ctl.ata_drive_low && media_ctl.ata_halt)
    else $error("ata not driven low");
  a_ata_float: assert property (
    ok && !ata_bus_enable [*4] |=> media_ctl.ata_pins_oe_n && media_ctl.ata_halt)
    else $error("ata pins not floated");
endmodule
`default_nettype wire

/* File: verif/sbsel_host_model.sv */
// Purpose: Host side of the interrupt pipe
// Assumes: Answer lands exactly one cycle after the token
// Notes:   Returns valid and nak as a two-bit code
`timescale 1ns/1ns
`default_nettype none
module sbsel_host_model
  import sbsel_pkg::*;
(
  // Clock
  input wire logic                     mclk,
  // Interrupt pipe
  output logic                         intr_in_token,
  input wire logic                     intr_data_valid,
  input wire logic                     intr_nak,
  input wire sbsel_pkg::sbsel_status_t intr_data
);
  import sbsel_pkg::*;
  initial intr_in_token = 1'b0;
  task automatic poll(output logic [1:0] ans, output sbsel_status_t word);
    @(posedge mclk);
    intr_in_token <= 1'b1;
    @(posedge mclk);
    intr_in_token <= 1'b0;
    @(posedge mclk);
    ans  = {intr_data_valid, intr_nak};
    word = intr_data;
  endtask
endmodule
`default_nettype wire

/* File: verif/sbsel_top_tb.sv */
// Purpose: Directed bench for the sideband block
// Assumes: Straps change only while reset is held
// Notes:   Eject hold shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module sbsel_top_tb;
  import sbsel_pkg::*;
  localparam int HOLD = 20;
  logic          mclk, resetn, bidi_oe_n, out_only_chain_sel, pads_hiz;
  logic [3:0]    test_sel;
  logic [10:0]   chain_ded_in;
  logic [19:0]   bidi_in, bidi_out;
  logic [13:0]   chain_out_only;
  logic          eject_button_n, usb_suspended, remote_wake_enabled;
  logic          eject_request, remote_wakeup, system_service_request;
  logic          drive_ready_in, high_speed_active, bus_powered_select;
  logic [2:0]    gpio_in;
  logic [7:0]    cfg_byte_0e, cfg_byte_0b;
  logic          intr_in_token, intr_data_valid, intr_nak, intr_pending;
  sbsel_status_t intr_data, word;
  logic          media_present_valid, ata_bus_enable, pres;
  sbsel_media_t  media_ctl;
  logic [1:0]    ans;
  logic [15:0]   exp;
  logic [19:0]   ej_cnt = '0, wk_cnt = '0;
  int            fails = 0, total_checks = 0;

  sbsel_top #(.HOLD_CYC(HOLD)) sbsel_top_i (
    .mclk(mclk), .resetn(resetn), .clk_en(1'b1), .test_sel(test_sel),
    .chain_ded_in(chain_ded_in), .bidi_in(bidi_in), .bidi_out(bidi_out),
    .bidi_oe_n(bidi_oe_n), .chain_out_only(chain_out_only),
    .out_only_chain_sel(out_only_chain_sel), .pads_hiz(pads_hiz),
    .eject_button_n(eject_button_n), .usb_suspended(usb_suspended),
    .remote_wake_enabled(remote_wake_enabled), .eject_request(eject_request),
    .remote_wakeup(remote_wakeup), .system_service_request(system_service_request),
    .drive_ready_in(drive_ready_in), .high_speed_active(high_speed_active),
    .bus_powered_select(bus_powered_select), .gpio_in(gpio_in),
    .cfg_byte_0e(cfg_byte_0e), .intr_in_token(intr_in_token),
    .intr_data_valid(intr_data_valid), .intr_nak(intr_nak), .intr_data(intr_data),
    .intr_pending(intr_pending), .cfg_byte_0b(cfg_byte_0b),
    .media_present_valid(media_present_valid), .ata_bus_enable(ata_bus_enable),
    .media_ctl(media_ctl));
  sbsel_host_model sbsel_host_model_i (.mclk(mclk), .intr_in_token(intr_in_token),
    .intr_data_valid(intr_data_valid), .intr_nak(intr_nak), .intr_data(intr_data));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (eject_request === 1'b1) ej_cnt++;
    if (remote_wakeup === 1'b1) wk_cnt++;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [19:0] seen, input logic [19:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic restart(input logic [3:0] code);
    test_sel <= code;
    resetn   <= 1'b0;
    step(16);
    resetn <= 1'b1;
    step(8);
  endtask
  // Cumulative chain, output j shows stage j modulo n
  function automatic logic [19:0] chain(input logic [19:0] din, input int n, input int m);
    logic [19:0] st, res;
    res   = '0;
    st    = '0;
    st[0] = din[0];
    for (int k = 1; k < n; k++) st[k] = ~(st[k-1] ^ din[k]);
    for (int j = 0; j < m; j++) res[j] = st[j % n];
    return res;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    step(40000);
    fails++;
    $display("BAD %0t run too long", $time);
    report_and_stop();
  end

  initial begin
    {resetn, test_sel, usb_suspended, remote_wake_enabled, system_service_request} = '0;
    {drive_ready_in, high_speed_active, bus_powered_select, gpio_in} = '0;
    {cfg_byte_0e, cfg_byte_0b, media_present_valid} = '0;
    {eject_button_n, ata_bus_enable} = 2'h3;
    chain_ded_in = 11'h5A3;
    bidi_in      = 20'hC3A5F;
    // Code is captured once, so every code needs its own reset
    for (int c = 0; c < 16; c++) begin
      restart(4'(c));
      check(pads_hiz, c == 2);
      check(bidi_oe_n, c != 3);
      check(bidi_out, c == 3 ? chain({9'h0, chain_ded_in}, 11, 20) : '0);
      check(out_only_chain_sel, c == 4);
      check(chain_out_only, c == 4 ? chain(bidi_in, 20, 14) : '0);
      sbsel_host_model_i.poll(ans, word);
      check(ans, c == 0 ? 2'h1 : 2'h0);
    end
    $display("test modes done");
    restart(4'h0);
    for (int p = 0; p < 2; p++) begin
      {drive_ready_in, high_speed_active, bus_powered_select} <= p ? 3'h2 : 3'h5;
      cfg_byte_0e <= p ? 8'h57 : 8'hA8;
      gpio_in     <= p ? 3'h2 : 3'h5;
      exp = p ? {5'h00, 3'h2, 5'h0A, 3'h2} : {5'h00, 3'h5, 5'h15, 3'h5};
      step(1);
      system_service_request <= 1'b1;
      step(5);
      check(intr_pending, 1'b1);
      gpio_in                <= ~gpio_in;
      system_service_request <= 1'b0;
      step(5);
      sbsel_host_model_i.poll(ans, word);
      check(ans, 2'h2);
      check(word, exp);
      check(intr_pending, 1'b0);
      sbsel_host_model_i.poll(ans, word);
      check(ans, 2'h1);
    end
    $display("interrupt pipe done");
    eject_button_n <= 1'b0;
    step(HOLD - 5);
    eject_button_n <= 1'b1;
    step(6);
    check(ej_cnt, 0);
    eject_button_n <= 1'b0;
    step(HOLD + 8);
    eject_button_n <= 1'b1;
    step(6);
    check(ej_cnt, 1);
    check(wk_cnt, 0);
    usb_suspended       <= 1'b1;
    remote_wake_enabled <= 1'b1;
    step(4);
    for (int w = 0; w < 2; w++) begin
      eject_button_n <= ~eject_button_n;
      step(8);
    end
    check(wk_cnt, 2);
    remote_wake_enabled <= 1'b0;
    eject_button_n      <= 1'b0;
    step(HOLD + 8);
    eject_button_n <= 1'b1;
    step(8);
    check(wk_cnt, 2);
    check(ej_cnt, 1);
    usb_suspended <= 1'b0;
    $display("eject and wakeup done");
    for (int i = 0; i < 16; i++) begin
      cfg_byte_0b         <= {3'h0, i[2], 1'b0, i[3], 2'h0};
      media_present_valid <= i[1];
      ata_bus_enable      <= i[0];
      pres = !i[3] || (i[1] == i[2]);
      step(6);
      check(media_ctl, {pres, !pres || !i[0], !pres, !pres && i[0], !i[0]});
    end
    $display("media done");
    report_and_stop();
  end
endmodule

bind sbsel_top sbsel_top_properties #(.HOLD_CYC(HOLD_CYC)) sbsel_top_properties_i (
  .mclk(mclk), .resetn(resetn), .test_sel(test_sel), .bidi_oe_n(bidi_oe_n),
  .out_only_chain_sel(out_only_chain_sel), .pads_hiz(pads_hiz),
  .eject_button_n(eject_button_n), .usb_suspended(usb_suspended),
  .remote_wake_enabled(remote_wake_enabled), .eject_request(eject_request),
  .remote_wakeup(remote_wakeup), .system_service_request(system_service_request),
  .intr_in_token(intr_in_token), .intr_data_valid(intr_data_valid),
  .intr_nak(intr_nak), .intr_data(intr_data), .intr_pending(intr_pending),
  .cfg_byte_0b(cfg_byte_0b), .media_present_valid(media_present_valid),
  .ata_bus_enable(ata_bus_enable), .media_ctl(media_ctl));
`default_nettype wire
